// >>> core/phyvs_pkg.sv
// Purpose: Shared constants and types for the PHY vendor register bank
// Assumes: AHB-Lite with 32-bit data, 16-bit registers in the low half
// Notes:   A register's byte address is four times its index
package phyvs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address = index * 4
  localparam logic [7:0] PHYVS_IDX_EXPCTL = 8'h18;
  localparam logic [7:0] PHYVS_IDX_INTCS  = 8'h1b;
  localparam logic [7:0] PHYVS_IDX_DIAG   = 8'h1d;
  localparam logic [7:0] PHYVS_IDX_STAT1  = 8'h1e;
  localparam logic [7:0] PHYVS_IDX_CTL2   = 8'h1f;

  // Index field inside the byte address
  localparam int PHYVS_IDX_HI = 9;
  localparam int PHYVS_IDX_LO = 2;

  // Field positions
  localparam int PHYVS_B_PRE_RST = 6;
  localparam int PHYVS_B_DIAG_EN = 15;
  localparam int PHYVS_B_INT_LVL = 9;
  localparam int PHYVS_B_XOVER   = 15;

  // Values after reset; fixed image of the unmodelled control bits
  localparam logic [15:0] PHYVS_EXPCTL_FIX = 16'h0801;
  localparam logic [15:0] PHYVS_CTL2_RST   = 16'h8100;

  // Preamble length in receive nibbles (seven bytes)
  localparam logic [3:0] PHYVS_PRE_NIB = 4'he;

  ////////////////////////////////////////////////////////////////////////////
  // Cable test outcome codes
  typedef enum logic [1:0] {
    PHYVS_DIAG_NORMAL = 2'h0,
    PHYVS_DIAG_OPEN   = 2'h1,
    PHYVS_DIAG_SHORT  = 2'h2,
    PHYVS_DIAG_FAIL   = 2'h3
  } phyvs_diag_t;

  // Receive preamble filter states
  typedef enum logic [2:0] {
    PHYVS_RX_IDLE = 3'h1,
    PHYVS_RX_PRE  = 3'h2,
    PHYVS_RX_PASS = 3'h4
  } phyvs_rx_st_t;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } phyvs_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } phyvs_ahb_rsp_t;

  // One receive nibble, stb marks a nibble present this cycle
  typedef struct packed {
    logic       stb;
    logic       dv;
    logic       er;
    logic [3:0] nib;
  } phyvs_mii_t;

  // Live line status from the transceiver core
  typedef struct packed {
    logic       flow_cap;
    logic       link_up;
    logic       pol_rev;
    logic       xover_st;
    logic       energy;
    logic       isolated;
    logic [2:0] op_mode;
  } phyvs_link_t;

  // Cable test completion from the diagnostic engine
  typedef struct packed {
    logic        done;
    phyvs_diag_t result;
    logic        short_cable;
    logic [8:0]  fault_dist;
  } phyvs_diag_in_t;

  typedef struct packed {
    logic         wr_pend;
    logic [7:0]   wr_idx;
    logic [15:0]  rdata;
    logic [7:0]   ien;
    logic [7:0]   ists;
    logic         pre_restore;
    logic         diag_run;
    logic [2:0]   diag_rsv;
    phyvs_diag_t  diag_res;
    logic         diag_short;
    logic [8:0]   diag_dist;
    logic [15:0]  ctl2;
    logic         irq_pin;
    phyvs_rx_st_t rx_st;
    logic [3:0]   rx_cnt;
    phyvs_mii_t   rx_out;
  } phyvs_state_t;

endpackage : phyvs_pkg

// >>> core/phyvs_regs.sv
// Purpose: Vendor status, interrupt and cable test registers of the PHY
// Assumes: All status and event inputs come from logic on ref_clk
// Notes:   Zero wait state AHB-Lite slave, always OKAY
//
// Contract
// RL1 - 10M: restore or strip seven preamble bytes
// RL2 - Eight interrupt enables, bits 15:8, reset 0
// RL3 - Events set status bits 7:0, reset 0
// RL4 - Remote fault, link up clear on read
// RL5 - Test enable self-clears when test completes
// RL6 - Two-bit cable test result, reset 00
// RL7 - Short cable indicator bit, reset 0
// RL8 - Read-only flow control capability bit
// RL9 - Polarity reversal and crossover state bits
// RL10 - Energy detect bit reflects receive signal
// RL11 - Isolate and link status bits, reset 0
// RL12 - Three-bit resolved operating mode field
// RL13 - Crossover algorithm select, reset 1
// RL14 - Interrupt pin polarity follows level bit
// RL15 - Interrupt asserts on enabled pending status
// RL16 - Status stays latched until status read
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module phyvs_regs
  import phyvs_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  input  wire phyvs_ahb_req_t ahb_i,
  output phyvs_ahb_rsp_t      ahb_o,
  input  wire logic [7:0]     evt_i,
  input  wire phyvs_link_t    link_i,
  input  wire phyvs_diag_in_t diag_i,
  input  wire logic           speed_10m_i,
  input  wire phyvs_mii_t     rx_i,
  output phyvs_mii_t          rx_o,
  output logic                irq_o,
  output logic                diag_run_o,
  output logic                xover_alg_sel_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State and decode
  phyvs_state_t q;
  phyvs_state_t d;
  logic         a_vld;
  logic [7:0]   a_idx;
  logic         rd_ints;
  logic         wr_diag;

  // Address phase taken on any selected active transfer with hready high
  assign a_vld   = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1];
  assign a_idx   = ahb_i.haddr[PHYVS_IDX_HI:PHYVS_IDX_LO];
  assign rd_ints = a_vld & ~ahb_i.hwrite & (a_idx == PHYVS_IDX_INTCS); // RL4
  assign wr_diag = q.wr_pend & (q.wr_idx == PHYVS_IDX_DIAG);

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer over the next-state image
  function automatic logic [15:0] rd_mux(input phyvs_state_t s,
                                         input phyvs_link_t  ls,
                                         input logic [7:0]   idx);
    logic [15:0] r;
    r = 16'h0000;
    case (idx)
      PHYVS_IDX_EXPCTL: begin
        r = PHYVS_EXPCTL_FIX;
        r[PHYVS_B_PRE_RST] = s.pre_restore;
      end
      PHYVS_IDX_INTCS: begin
        r = {s.ien, s.ists};
      end
      PHYVS_IDX_DIAG: begin
        r = {s.diag_run, s.diag_res, s.diag_short, s.diag_rsv,
             s.diag_dist};                               // RL6
      end
      PHYVS_IDX_STAT1: begin
        r = {6'h00,
             ls.flow_cap,                                // RL8
             ls.link_up,                                 // RL11
             ls.pol_rev,                                 // RL9
             1'b0,
             ls.xover_st,                                // RL9
             ls.energy,                                  // RL10
             ls.isolated,                                // RL11
             ls.op_mode};                                // RL12
      end
      PHYVS_IDX_CTL2: begin
        r = s.ctl2;
      end
      default: begin
        r = 16'h0000;
      end
    endcase
    return r;
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic rx_take;
    logic irq_act;
    rx_take = 1'b0;
    irq_act = 1'b0;
    d       = q;

    // Latch the address phase for the following data phase
    d.wr_pend = a_vld & ahb_i.hwrite;
    d.wr_idx  = a_idx;

    // Test completion clears the enable and captures results
    if (q.diag_run && diag_i.done) begin
      d.diag_run   = 1'b0;                               // RL5
      d.diag_res   = diag_i.result;                      // RL6
      d.diag_short = diag_i.short_cable;                 // RL7
      d.diag_dist  = diag_i.fault_dist;
    end

    // Data phase writes; a new start beats a same-cycle completion
    if (q.wr_pend) begin
      case (q.wr_idx)
        PHYVS_IDX_EXPCTL: begin
          d.pre_restore = ahb_i.hwdata[PHYVS_B_PRE_RST];
        end
        PHYVS_IDX_INTCS: begin
          d.ien = ahb_i.hwdata[15:8];                    // RL2
        end
        PHYVS_IDX_DIAG: begin
          d.diag_run = ahb_i.hwdata[PHYVS_B_DIAG_EN];    // RL5
          d.diag_rsv = ahb_i.hwdata[11:9];
        end
        PHYVS_IDX_CTL2: begin
          d.ctl2 = ahb_i.hwdata[15:0];                   // RL13
        end
        default: begin
          d.ctl2 = q.ctl2;
        end
      endcase
    end

    // Read data comes from the image that includes this write
    if (a_vld && !ahb_i.hwrite) begin
      d.rdata = rd_mux(d, link_i, a_idx);
    end

    // Status latches until read; a new event beats the clear
    d.ists = (q.ists & ~{8{rd_ints}}) | evt_i;           // RL3

    // Interrupt pin from enabled pending status and polarity
    irq_act   = |(d.ien & d.ists);                       // RL15
    d.irq_pin = d.ctl2[PHYVS_B_INT_LVL] ? irq_act : ~irq_act; // RL14

    // Receive preamble filter; mode is taken at frame start
    unique case (q.rx_st)
      PHYVS_RX_IDLE: begin
        if (rx_i.stb && rx_i.dv) begin
          if (speed_10m_i && !q.pre_restore) begin
            d.rx_st  = PHYVS_RX_PRE;                     // RL1
            d.rx_cnt = 4'h1;
          end else begin
            d.rx_st = PHYVS_RX_PASS;
            rx_take = 1'b1;                              // RL1
          end
        end
      end
      PHYVS_RX_PRE: begin
        if (!rx_i.dv) begin
          d.rx_st = PHYVS_RX_IDLE;
        end else if (rx_i.stb) begin
          if (q.rx_cnt == PHYVS_PRE_NIB - 4'h1) begin
            d.rx_st = PHYVS_RX_PASS;                     // RL1
          end else begin
            d.rx_cnt = q.rx_cnt + 4'h1;
          end
        end
      end
      PHYVS_RX_PASS: begin
        rx_take = rx_i.dv;
        if (!rx_i.dv) begin
          d.rx_st = PHYVS_RX_IDLE;
        end
      end
    endcase
    d.rx_out.stb = rx_i.stb & rx_take;
    d.rx_out.dv  = rx_i.dv & rx_take;
    d.rx_out.er  = rx_i.er & rx_take;
    d.rx_out.nib = rx_i.nib;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{wr_pend:     1'b0,
             wr_idx:      8'h00,
             rdata:       16'h0000,
             ien:         8'h00,
             ists:        8'h00,
             pre_restore: 1'b0,
             diag_run:    1'b0,
             diag_rsv:    3'h0,
             diag_res:    PHYVS_DIAG_NORMAL,
             diag_short:  1'b0,
             diag_dist:   9'h000,
             ctl2:        PHYVS_CTL2_RST,
             irq_pin:     1'b1,
             rx_st:       PHYVS_RX_IDLE,
             rx_cnt:      4'h0,
             rx_out:      '{stb: 1'b0, dv: 1'b0, er: 1'b0, nib: 4'h0}};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign ahb_o.hrdata    = {16'h0000, q.rdata};
  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp     = 1'b0;
  assign rx_o            = q.rx_out;
  assign irq_o           = q.irq_pin;
  assign diag_run_o      = q.diag_run;
  assign xover_alg_sel_o = q.ctl2[PHYVS_B_XOVER];          // RL13

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // Enables move only on a write to their register
  a_ien_hold: assert property ( // RL2
    !(q.wr_pend && q.wr_idx == PHYVS_IDX_INTCS) |=> $stable(q.ien))
    else $error("Interrupt enables changed without a write");

  // Every event shows up in status on the next edge
  a_evt_latch: assert property ( // RL3
    (evt_i != 8'h00) |=> ((q.ists & $past(evt_i)) == $past(evt_i)))
    else $error("Event did not set its status bit");

  // A status read with no new event leaves status empty
  a_rd_clear: assert property ( // RL4
    (rd_ints && evt_i == 8'h00) |=> (q.ists == 8'h00))
    else $error("Status read did not clear status");

  // Without a read, set status bits stay set
  a_sts_hold: assert property ( // RL16
    (!rd_ints && q.ists != 8'h00)
      |=> ((q.ists & $past(q.ists)) == $past(q.ists)))
    else $error("Status bit lost without a read");

  // Completion clears the enable and captures the outcome
  a_diag_done: assert property ( // RL5
    (q.diag_run && diag_i.done && !wr_diag)
      |=> (!q.diag_run && q.diag_res == $past(diag_i.result)))
    else $error("Cable test completion not handled");

  // Short cable flag follows the completed test
  a_diag_short: assert property ( // RL7
    (q.diag_run && diag_i.done && !wr_diag)
      |=> (q.diag_short == $past(diag_i.short_cable)))
    else $error("Short cable flag not captured");

  // Line status read returns the live status word
  a_stat_read: assert property ( // RL11
    (a_vld && !ahb_i.hwrite && a_idx == PHYVS_IDX_STAT1)
      |=> (q.rdata == {6'h00, $past(link_i.flow_cap),
                       $past(link_i.link_up), $past(link_i.pol_rev),
                       1'b0, $past(link_i.xover_st),
                       $past(link_i.energy), $past(link_i.isolated),
                       $past(link_i.op_mode)}))
    else $error("Line status read mismatch");

  // Pending enabled status drives the pin to its active level
  a_irq_active: assert property ( // RL15
    ((q.ien & q.ists) != 8'h00)
      |-> (q.irq_pin == q.ctl2[PHYVS_B_INT_LVL]))
    else $error("Interrupt not asserted");

  // No pending enabled status keeps the pin inactive
  a_irq_idle: assert property ( // RL14
    ((q.ien & q.ists) == 8'h00)
      |-> (q.irq_pin != q.ctl2[PHYVS_B_INT_LVL]))
    else $error("Interrupt pin at wrong idle level");

  // Crossover select takes the written value
  a_xover_wr: assert property ( // RL13
    (q.wr_pend && q.wr_idx == PHYVS_IDX_CTL2)
      |=> (xover_alg_sel_o == $past(ahb_i.hwdata[PHYVS_B_XOVER])))
    else $error("Crossover select not written");

  // Nothing is forwarded while preamble is being removed
  a_rx_strip: assert property ( // RL1
    (q.rx_st == PHYVS_RX_PRE) |=> !q.rx_out.stb)
    else $error("Preamble nibble forwarded");

  // A passed frame forwards its first nibble unchanged
  a_rx_pass: assert property ( // RL1
    (q.rx_st == PHYVS_RX_IDLE && rx_i.stb && rx_i.dv
     && !(speed_10m_i && !q.pre_restore))
      |=> (q.rx_out.stb && q.rx_out.nib == $past(rx_i.nib)))
    else $error("Frame start not forwarded");

  // A status read returns status as it was before the clear
  a_rd_status: assert property ( // RL16
    rd_ints |=> (q.rdata[7:0] == $past(q.ists)))
    else $error("Status read lost pending bits");

  // A write to the test register starts or aborts the test
  a_diag_write: assert property ( // RL5
    wr_diag |=> (q.diag_run == $past(ahb_i.hwdata[PHYVS_B_DIAG_EN])))
    else $error("Test enable not written");

  // Results stay put while no test runs
  a_diag_keep: assert property ( // RL6
    !q.diag_run
      |=> ($stable(q.diag_res) && $stable(q.diag_short)
           && $stable(q.diag_dist)))
    else $error("Cable test result changed while idle");

  // Crossover and level bits move only on a write
  a_ctl2_hold: assert property ( // RL13
    !(q.wr_pend && q.wr_idx == PHYVS_IDX_CTL2) |=> $stable(q.ctl2))
    else $error("Control two changed without a write");

  // Expanded control reads its fixed image and the restore bit
  a_exp_read: assert property ( // RL1
    (a_vld && !ahb_i.hwrite && a_idx == PHYVS_IDX_EXPCTL)
      |=> (q.rdata[PHYVS_B_PRE_RST] == q.pre_restore
           && (q.rdata | 16'h0040) == (PHYVS_EXPCTL_FIX | 16'h0040)))
    else $error("Expanded control read mismatch");

  // Strip counter stays inside the preamble span
  a_pre_count: assert property ( // RL1
    (q.rx_st == PHYVS_RX_PRE)
      |-> (q.rx_cnt != 4'h0 && q.rx_cnt < PHYVS_PRE_NIB))
    else $error("Preamble counter out of range");

  c_irq_raise: cover property ($changed(q.irq_pin));
  c_diag_done: cover property (q.diag_run ##1 !q.diag_run);
  c_rd_clear:  cover property (rd_ints && q.ists != 8'h00);
  c_rx_strip:  cover property (q.rx_st == PHYVS_RX_PRE
                               ##1 q.rx_st == PHYVS_RX_PASS);
  c_idle_done: cover property (!q.diag_run && diag_i.done);

endmodule : phyvs_regs

`default_nettype wire

// >>> sim/phyvs_mgmt_model.sv
// Purpose: Station management master on the AHB-Lite register bus
// Assumes: Single word transfers, slave always answers OKAY
// Notes:   Waits on hready with no fixed latency
`timescale 1ns/1ps
`default_nettype none

module phyvs_mgmt_model
  import phyvs_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire phyvs_ahb_rsp_t rsp,
  output var  phyvs_ahb_req_t req
);
  phyvs_ahb_req_t m = '0;

  // Bus hready is the only slave's hreadyout
  always_comb begin
    req        = m;
    req.hready = rsp.hreadyout;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    m.hsel   <= 1'b1;
    m.htrans <= 2'h2;
    m.haddr  <= {22'h0, idx, 2'h0};
    m.hwrite <= w;
    m.hsize  <= 3'h2;
    do @(posedge ref_clk); while (rsp.hreadyout !== 1'b1);
    m.hsel   <= 1'b0;
    m.htrans <= 2'h0;
    m.hwdata <= wd;
    do @(posedge ref_clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : xfer
endmodule : phyvs_mgmt_model
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench of the PHY vendor register bank
// Assumes: Zero wait state slave, registered interrupt pin
// Notes:   Register traffic goes through the management model
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module tb;
  import phyvs_pkg::*;
  logic           ref_clk = 1'b0;
  logic           rst_b   = 1'b0;
  phyvs_ahb_req_t ahb_i;
  phyvs_ahb_rsp_t ahb_o;
  logic [7:0]     evt_i   = '0;
  phyvs_link_t    link_i  = '0;
  phyvs_diag_in_t diag_i  = '0;
  logic           speed_10m_i = 1'b0;
  phyvs_mii_t     rx_i    = '0;
  phyvs_mii_t     rx_o;
  logic           irq_o, diag_run_o, xover_alg_sel_o;
  int             fails = 0, checks = 0, rx_n = 0;
  logic [3:0]     rx_first;
  logic [31:0]    rd;
  logic [8:0]     lv[5] = '{9'h000, 9'h1f9, 9'h0aa, 9'h155, 9'h1fe};

  phyvs_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .ahb_i(ahb_i),
    .ahb_o(ahb_o), .evt_i(evt_i), .link_i(link_i), .diag_i(diag_i),
    .speed_10m_i(speed_10m_i), .rx_i(rx_i), .rx_o(rx_o), .irq_o(irq_o),
    .diag_run_o(diag_run_o), .xover_alg_sel_o(xover_alg_sel_o));
  phyvs_mgmt_model mst_u (.ref_clk(ref_clk), .rsp(ahb_o), .req(ahb_i));

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Count delivered nibbles and keep the first one of a frame
  always @(posedge ref_clk) begin
    if (rx_o.stb === 1'b1) begin
      if (rx_n == 0) rx_first = rx_o.nib;
      rx_n++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    mst_u.xfer(1'b1, idx, {16'h0, d}, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [15:0] e);
    mst_u.xfer(1'b0, idx, 32'h0, rd);
    `CHK(rd, {16'h0, e})
  endtask : rdc

  // Sixteen strobed nibbles valued 0..15, returns delivered count
  task automatic frame(output int n);
    rx_n = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk) rx_i <= '{1'b1, 1'b1, 1'b0, 4'(i)};
    end
    @(posedge ref_clk) rx_i <= '0;
    repeat (3) @(posedge ref_clk);
    n = rx_n;
  endtask : frame

  task automatic print_verdict;
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #200us;
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    int n;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset images, unmapped index reads zero
    rdc(PHYVS_IDX_EXPCTL, PHYVS_EXPCTL_FIX);
    rdc(PHYVS_IDX_INTCS, 16'h0000);
    rdc(PHYVS_IDX_DIAG, 16'h0000);
    rdc(PHYVS_IDX_CTL2, 16'h8100);
    rdc(8'h05, 16'h0000);
    `CHK(xover_alg_sel_o, 1'b1)
    `CHK(irq_o, 1'b1)
    // Each event latches; only link-up is enabled for the pin
    wr(PHYVS_IDX_INTCS, 16'h0100);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk) evt_i <= 8'(1 << i);
      @(posedge ref_clk) evt_i <= '0;
      repeat (4) @(posedge ref_clk);
      `CHK(irq_o, (i != 0))
      rdc(PHYVS_IDX_INTCS, 16'h0100 | 16'(1 << i));
      rdc(PHYVS_IDX_INTCS, 16'h0100);
      repeat (2) @(posedge ref_clk);
      `CHK(irq_o, 1'b1)
    end
    // Active high pin, other algorithm
    wr(PHYVS_IDX_CTL2, 16'h0200);
    repeat (2) @(posedge ref_clk);
    `CHK(irq_o, 1'b0)
    `CHK(xover_alg_sel_o, 1'b0)
    @(posedge ref_clk) evt_i <= 8'h01;
    @(posedge ref_clk) evt_i <= '0;
    repeat (4) @(posedge ref_clk);
    `CHK(irq_o, 1'b1)
    rdc(PHYVS_IDX_INTCS, 16'h0101);
    // Live status, every documented mode code
    for (int j = 0; j < 5; j++) begin
      @(posedge ref_clk) link_i <= lv[j];
      rdc(PHYVS_IDX_STAT1, {6'h0, lv[j][8:6], 1'b0, lv[j][5:0]});
    end
    // Cable test with every outcome code
    for (int c = 0; c < 4; c++) begin
      wr(PHYVS_IDX_DIAG, 16'h8000);
      rdc(PHYVS_IDX_DIAG, (c == 0) ? 16'h8000 :
          {1'b1, 2'(c - 1), 1'(c - 1), 3'h0, 9'h1a5});
      `CHK(diag_run_o, 1'b1)
      @(posedge ref_clk) diag_i <= '{1'b1, phyvs_diag_t'(c), c[0], 9'h1a5};
      @(posedge ref_clk) diag_i.done <= 1'b0;
      repeat (2) @(posedge ref_clk);
      `CHK(diag_run_o, 1'b0)
      rdc(PHYVS_IDX_DIAG, {1'b0, 2'(c), c[0], 3'h0, 9'h1a5});
    end
    // Completion while idle is ignored
    @(posedge ref_clk) diag_i <= '{1'b1, PHYVS_DIAG_NORMAL, 1'b0, 9'h000};
    @(posedge ref_clk) diag_i.done <= 1'b0;
    rdc(PHYVS_IDX_DIAG, 16'h7000 | 16'h01a5);
    // 10M preamble strip, then restore
    speed_10m_i <= 1'b1;
    frame(n);
    `CHK(n, 2)
    `CHK(rx_first, 4'he)
    wr(PHYVS_IDX_EXPCTL, 16'h0040);
    rdc(PHYVS_IDX_EXPCTL, PHYVS_EXPCTL_FIX | 16'h0040);
    frame(n);
    `CHK(n, 16)
    `CHK(rx_first, 4'h0)
    // 100M passes the preamble with the restore bit clear
    wr(PHYVS_IDX_EXPCTL, 16'h0000);
    speed_10m_i <= 1'b0;
    frame(n);
    `CHK(n, 16)
    `CHK(rx_first, 4'h0)
    print_verdict();
  end
endmodule : tb
`default_nettype wire
